// ===== design/fbc_pkg.sv
package fbc_pkg;
	// Clock period, ps
	localparam int unsigned CLK_PERIOD_PS = 4000;

	// Reset pulse width, least, ns
	localparam int unsigned RESET_PULSE_NS = 100;
	localparam int unsigned RESET_PULSE_CYC =
		(RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Abort shutdown times, longest, us
	localparam int unsigned ABORT_ERASE_US   = 22;
	localparam int unsigned ABORT_PROGRAM_US = 12;
	localparam int unsigned ABORT_ERASE_CYC  = ABORT_ERASE_US * 1000000 / CLK_PERIOD_PS;
	localparam int unsigned ABORT_PROG_CYC   = ABORT_PROGRAM_US * 1000000 / CLK_PERIOD_PS;

	// Plain recovery defaults (ns), not given by figures
	localparam int unsigned READ_VALID_NS  = 150;
	localparam int unsigned WRITE_DELAY_NS = 150;
	localparam int unsigned READ_VALID_CYC =
		(READ_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WRITE_DELAY_CYC =
		(WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Bus cycle phase lengths
	localparam int unsigned STROBE_CYC  = 20;
	localparam int unsigned SETUP_CYC   = 2;

	localparam int unsigned CNT_W = 16;
	localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;

	typedef enum logic [2:0] {
		FBC_RESET   = 3'b000,
		FBC_IDLE    = 3'b001,
		FBC_SETUP   = 3'b011,
		FBC_STROBE  = 3'b010,
		FBC_HOLD    = 3'b110,
		FBC_RECOVER = 3'b111
	} fbc_state_t;
endpackage

// ===== design/fbc_delay.sv
`timescale 1ns/100ps
// Down counter: load a count, done pulses when it reaches zero
module fbc_delay #(
	parameter int unsigned W = 16
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_q;

	// Counter
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// Done pulses on last count
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			done <= 1'b0;
		else
			done <= !load && cnt_q == {{(W-1){1'b0}}, 1'b1};
	end

	assign busy = cnt_q != '0;
endmodule // fbc_delay

// ===== design/fbc_host.sv
`timescale 1ns/100ps
// Contract
// [R1] Read: select low, output enable low, write strobe high, reset high.
// [R2] Write: select and write strobe low, output enable and reset high.
// [R3] Device latches write data on first rising strobe or select edge.
// [R4] Output enable high floats device data lines.
// [R5] Select high puts device in standby with floating outputs.
// [R6] Program or erase continues after deselect until done.
// [R7] Reset low for pulse width deselects and powers down device.
// [R8] Host waits read-valid and write delays after reset release.
// [R9] After reset: read-array mode, status 0x80, blocks locked.
// [R10] Reset during program or erase aborts it, leaving invalid data.
// [R11] Abort needs shutdown interval; end mode depends on reset level.
// [R12] After abort, host counts recovery from end of shutdown interval.
// [R13] Reads during program or erase return status.
// [R14] Drive device reset from the same reset as the host.
// [R15] Device state machine runs operations alone; status reports progress.
// [R16] Reset low time at least 100 ns.
// [R17] Shutdown lasts up to 22 us erase, 12 us program.
// [R18] Idle reset completes within 100 ns.
module fbc_host #(
	parameter int unsigned ADDR_W          = 20,
	parameter int unsigned DATA_W          = 16,
	parameter int unsigned ABORT_ERASE_CYC = fbc_pkg::ABORT_ERASE_CYC,
	parameter int unsigned ABORT_PROG_CYC  = fbc_pkg::ABORT_PROG_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// User side
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqData,
	output logic                   reqReady,
	output logic                   rspValid,
	output logic [DATA_W-1:0]      rspData,
	input  wire logic              resetReq,
	input  wire logic              opBusy,
	input  wire logic              opErase,
	output logic                   inReset,
	// Flash pins
	output logic [ADDR_W-1:0]      flashAddr,
	output logic                   chipSelectN,
	output logic                   outputEnableN,
	output logic                   writeStrobeN,
	output logic                   resetPowerdownN,
	input  wire logic [DATA_W-1:0] dqIn,
	output logic [DATA_W-1:0]      dqOut,
	output logic                   dqOe
);
	localparam int unsigned CW = fbc_pkg::CNT_W + 2;

	fbc_pkg::fbc_state_t state_q;
	logic                isWrite_q;
	logic [CW-1:0]       phase_q;
	logic                rstBusy_q;
	logic                pulseMet_q;
	logic                startPulse_q;
	logic                dlyLoad;
	logic [CW-1:0]       dlyCount;
	logic                dlyBusy;
	logic                dlyDone;
	logic [DATA_W-1:0]   dqS1_q;
	logic [DATA_W-1:0]   dqS2_q;
	logic [DATA_W-1:0]   dqS3_q;

	// Narrow a cycle count to the counter width
	function automatic logic [CW-1:0] cyc(input int unsigned n);
		cyc = CW'(n);
	endfunction

	// Pin data from outside the clock domain
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			dqS1_q <= '0;
			dqS2_q <= '0;
			dqS3_q <= '0;
		end
		else
		begin
			dqS1_q <= dqIn;
			dqS2_q <= dqS1_q;
			dqS3_q <= dqS2_q;
		end
	end

	// Shared delay counter: reset pulse, shutdown, recovery
	fbc_delay #(
		.W     (CW)
	) u_delay (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.load    (dlyLoad),
		.count   (dlyCount),
		.busy    (dlyBusy),
		.done    (dlyDone)
	);

	// Delay load select
	always_comb
	begin
		dlyLoad  = 1'b0;
		dlyCount = '0;
		if (state_q != fbc_pkg::FBC_RESET && (resetReq || !resetn))
		begin
			dlyLoad = 1'b1;
			if (opBusy && opErase)                                      // R17
				dlyCount = cyc(ABORT_ERASE_CYC);                         // R10
			else if (opBusy)
				dlyCount = cyc(ABORT_PROG_CYC);                          // R11
			else
				dlyCount = cyc(fbc_pkg::RESET_PULSE_CYC);                // R16
		end
		else if (state_q == fbc_pkg::FBC_RESET && startPulse_q)
		begin
			dlyLoad  = 1'b1;                                            // R16 R18
			dlyCount = cyc(fbc_pkg::RESET_PULSE_CYC);
		end
		else if (state_q == fbc_pkg::FBC_RESET && !resetReq && !rstBusy_q && pulseMet_q)
		begin
			dlyLoad  = 1'b1;                                            // R8
			dlyCount = cyc(fbc_pkg::READ_VALID_CYC > fbc_pkg::WRITE_DELAY_CYC ?
				fbc_pkg::READ_VALID_CYC : fbc_pkg::WRITE_DELAY_CYC);     // R12
		end
	end

	// Arms a full reset pulse on the first cycle after resetn
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			startPulse_q <= 1'b1;
		else
			startPulse_q <= 1'b0;                                       // R16
	end

	// Reset pulse and shutdown tracking
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rstBusy_q  <= 1'b1;
			pulseMet_q <= 1'b0;
		end
		else if (dlyLoad && state_q != fbc_pkg::FBC_RESET)
		begin
			rstBusy_q  <= 1'b1;
			pulseMet_q <= 1'b0;
		end
		else if (state_q == fbc_pkg::FBC_RESET && rstBusy_q && !dlyBusy && !dlyLoad)
		begin
			rstBusy_q  <= 1'b0;                                         // R11
			pulseMet_q <= 1'b1;
		end
		else if (state_q == fbc_pkg::FBC_RESET && dlyLoad)
			pulseMet_q <= 1'b0;
	end

	// Bus state machine
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			state_q   <= fbc_pkg::FBC_RESET;                             // R14
			phase_q   <= '0;
			isWrite_q <= 1'b0;
		end
		else
		begin
			case (state_q)
			fbc_pkg::FBC_RESET:
				if (dlyLoad && !rstBusy_q)
					state_q <= fbc_pkg::FBC_RECOVER;
			fbc_pkg::FBC_RECOVER:
				if (resetReq)
					state_q <= fbc_pkg::FBC_RESET;
				else if (dlyDone || !dlyBusy)
					state_q <= fbc_pkg::FBC_IDLE;                       // R8
			fbc_pkg::FBC_IDLE:
				if (resetReq)
					state_q <= fbc_pkg::FBC_RESET;                      // R7
				else if (reqValid)
				begin
					isWrite_q <= reqWrite;
					phase_q   <= cyc(fbc_pkg::SETUP_CYC);
					state_q   <= fbc_pkg::FBC_SETUP;
				end
			fbc_pkg::FBC_SETUP:
				if (phase_q == cyc(1))
				begin
					phase_q <= cyc(fbc_pkg::STROBE_CYC);
					state_q <= fbc_pkg::FBC_STROBE;
				end
				else
					phase_q <= phase_q - 1'b1;
			fbc_pkg::FBC_STROBE:
				if (phase_q == cyc(1))
				begin
					phase_q <= cyc(fbc_pkg::SETUP_CYC);
					state_q <= fbc_pkg::FBC_HOLD;                       // R3
				end
				else
					phase_q <= phase_q - 1'b1;
			fbc_pkg::FBC_HOLD:
				if (phase_q == cyc(1))
					state_q <= fbc_pkg::FBC_IDLE;
				else
					phase_q <= phase_q - 1'b1;
			default:
				state_q <= fbc_pkg::FBC_RESET;
			endcase
		end
	end

	// Pin drive
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			resetPowerdownN <= 1'b0;
			chipSelectN     <= 1'b1;
			outputEnableN   <= 1'b1;
			writeStrobeN    <= 1'b1;
			dqOe            <= 1'b0;
			dqOut           <= '0;
			flashAddr       <= '0;
		end
		else
		begin
			resetPowerdownN <= !(state_q == fbc_pkg::FBC_RESET && (rstBusy_q || resetReq)); // R7
			chipSelectN     <= !(state_q == fbc_pkg::FBC_SETUP || state_q == fbc_pkg::FBC_STROBE
				|| state_q == fbc_pkg::FBC_HOLD);                        // R5
			outputEnableN   <= !(!isWrite_q && (state_q == fbc_pkg::FBC_STROBE
				|| state_q == fbc_pkg::FBC_SETUP));                      // R1
			writeStrobeN    <= !(isWrite_q && state_q == fbc_pkg::FBC_STROBE); // R2
			dqOe            <= isWrite_q && (state_q == fbc_pkg::FBC_SETUP
				|| state_q == fbc_pkg::FBC_STROBE || state_q == fbc_pkg::FBC_HOLD); // R4
			if (state_q == fbc_pkg::FBC_IDLE && reqValid)
			begin
				flashAddr <= reqAddr;
				dqOut     <= reqData;
			end
		end
	end

	// Read data capture at end of strobe, status or array
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rspValid <= 1'b0;
			rspData  <= '0;
		end
		else
		begin
			rspValid <= state_q == fbc_pkg::FBC_STROBE && phase_q == cyc(1) && !isWrite_q;
			if (state_q == fbc_pkg::FBC_STROBE && phase_q == cyc(1) && !isWrite_q)
				rspData <= dqS3_q;                                       // R13
		end
	end

	assign reqReady = state_q == fbc_pkg::FBC_IDLE && !resetReq;
	assign inReset  = state_q == fbc_pkg::FBC_RESET || state_q == fbc_pkg::FBC_RECOVER;
endmodule // fbc_host

// ===== verif/fbc_host_monitor.sv
`timescale 1ns/100ps
module fbc_host_monitor (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic resetReq,
	input wire logic chipSelectN,
	input wire logic outputEnableN,
	input wire logic writeStrobeN,
	input wire logic resetPowerdownN,
	input wire logic dqOe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] lowCnt;
	logic [7:0] highCnt;
	// Cycles spent in reset and since leaving it
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || resetPowerdownN)
			lowCnt <= 8'h00;
		else if (lowCnt != 8'hff)
			lowCnt <= lowCnt + 8'h01;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || !resetPowerdownN)
			highCnt <= 8'h00;
		else if (highCnt != 8'hff)
			highCnt <= highCnt + 8'h01;
	end
	a_read_pins: assert property (!outputEnableN |-> !chipSelectN && writeStrobeN && resetPowerdownN)
		else $error("read pins wrong");
	a_write_pins: assert property (!writeStrobeN |-> !chipSelectN && outputEnableN && dqOe)
		else $error("write pins wrong");
	a_strobe_first: assert property ($rose(writeStrobeN) |-> !chipSelectN && dqOe)
		else $error("select left before strobe");
	a_bus_no_fight: assert property (!outputEnableN |-> !dqOe)
		else $error("host drives during read");
	a_reset_float: assert property (!resetPowerdownN |-> chipSelectN && outputEnableN && !dqOe)
		else $error("pins active in reset");
	a_pulse_width: assert property ($rose(resetPowerdownN) |-> $past(lowCnt) >= 8'h19)
		else $error("reset pulse short");
	a_recover_wait: assert property ($fell(chipSelectN) |-> highCnt >= 8'h25)
		else $error("access too soon after reset");
	a_read_answer: assert property ($rose(outputEnableN) |-> $past(rspValid))
		else $error("no read response");
	a_read_start: assert property (reqValid && reqReady && !reqWrite |-> ##[1:4] !outputEnableN)
		else $error("read not started");
	a_refuse_reset: assert property (resetReq |-> !reqReady)
		else $error("request taken in reset");
endmodule // fbc_host_monitor
bind fbc_host fbc_host_monitor mon_u (.sys_clk, .resetn, .reqValid, .reqWrite, .reqReady,
	.rspValid, .resetReq, .chipSelectN, .outputEnableN, .writeStrobeN, .resetPowerdownN, .dqOe);

// ===== verif/fbc_flash_model.sv
`timescale 1ns/100ps
module fbc_flash_model (
	input  wire logic [19:0] flashAddr,
	input  wire logic        chipSelectN,
	input  wire logic        outputEnableN,
	input  wire logic        writeStrobeN,
	input  wire logic        resetPowerdownN,
	input  wire logic        opBusy,
	input  wire logic [15:0] dqOut,
	input  wire logic        dqOe,
	output logic      [15:0] dqIn
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] val;
	logic [15:0] lastQ = 16'h0000;
	logic        drive;
	// Latch write on first rising strobe or select
	always @(posedge writeStrobeN or posedge chipSelectN)
		if (resetPowerdownN && (writeStrobeN ^ chipSelectN))
			mem[flashAddr] = dqOut;
	// Drive only when selected, enabled, out of reset
	assign drive = resetPowerdownN && !chipSelectN && !outputEnableN && writeStrobeN;
	// Status while busy, else array; released bus shows inverse
	always @*
	begin
		val = mem.exists(flashAddr) ? mem[flashAddr] : ~flashAddr[15:0];
		if (opBusy)
			val = 16'h0000;
		if (drive)
			lastQ = val;
		dqIn = dqOe ? dqOut : drive ? val : ~lastQ;
	end
endmodule // fbc_flash_model

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	localparam int ERASE_CYC = 60;
	localparam int PROG_CYC  = 40;
	logic        sys_clk, resetn, reqValid, reqWrite, resetReq, opBusy, opErase;
	logic        reqReady, rspValid, inReset, chipSelectN, outputEnableN, writeStrobeN;
	logic        resetPowerdownN, dqOe;
	logic [19:0] reqAddr, flashAddr;
	logic [15:0] reqData, rspData, dqIn, dqOut, rdData;
	int          miscompares, checks_done, cyc;
	fbc_host #(.ABORT_ERASE_CYC(ERASE_CYC), .ABORT_PROG_CYC(PROG_CYC)) dut_u (.sys_clk, .resetn,
		.reqValid, .reqWrite, .reqAddr, .reqData, .reqReady, .rspValid, .rspData, .resetReq,
		.opBusy, .opErase, .inReset, .flashAddr, .chipSelectN, .outputEnableN, .writeStrobeN,
		.resetPowerdownN, .dqIn, .dqOut, .dqOe);
	fbc_flash_model flash_u (.flashAddr, .chipSelectN, .outputEnableN, .writeStrobeN,
		.resetPowerdownN, .opBusy, .dqOut, .dqOe, .dqIn);
	// Clock and hang guard
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	task automatic xfer(input logic wr, input logic [19:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(negedge sys_clk);
		{reqValid, reqWrite, reqAddr, reqData} = {1'b1, wr, a, d};
		n = 0;
		while (reqReady !== 1'b1 && n++ < 2000)
			@(negedge sys_clk);
		if (n > 2000)
		begin
			miscompares++;
			$display("MISMATCH %0t request not taken", $time);
		end
		@(negedge sys_clk);
		reqValid = 1'b0;
		n = 0;
		while (!wr && rspValid !== 1'b1 && n++ < 100)
			@(negedge sys_clk);
		if (n > 100)
		begin
			miscompares++;
			$display("MISMATCH %0t no read response", $time);
		end
		q = rspData;
	endtask
	task automatic t_basic();
		@(negedge sys_clk);
		chk({15'h0000, resetPowerdownN}, 16'h0000, "reset pin");
		xfer(1'b0, 20'h00123, 16'h0000, rdData);
		chk(rdData, 16'hfedc, "array read after reset");
		xfer(1'b1, 20'h00010, 16'hbeef, rdData);
		xfer(1'b1, 20'hfffff, 16'h1234, rdData);
		xfer(1'b0, 20'h00010, 16'h0000, rdData);
		chk(rdData, 16'hbeef, "read back low");
		xfer(1'b0, 20'hfffff, 16'h0000, rdData);
		chk(rdData, 16'h1234, "read back top");
		$display("test basic done");
	endtask
	task automatic t_abort();
		int n;
		int hold;
		for (int e = 0; e < 2; e++)
		begin
			hold = e ? 80 : 3;
			opBusy = 1'b1;
			opErase = e[0];
			xfer(1'b0, 20'h00010, 16'h0000, rdData);
			chk(rdData, 16'h0000, "status while busy");
			@(negedge sys_clk);
			resetReq = 1'b1;
			repeat (hold) @(negedge sys_clk);
			chk({15'h0000, resetPowerdownN | reqReady}, 16'h0000, "held in reset");
			resetReq = 1'b0;
			opBusy = 1'b0;
			n = 0;
			while (inReset !== 1'b0 && n++ < 2000)
				@(negedge sys_clk);
			if (n > 2000)
			begin
				miscompares++;
				$display("MISMATCH %0t reset never left", $time);
			end
			n = n + hold;
			chk({15'h0000, n >= (e ? hold : PROG_CYC) + 38}, 16'h0001, "abort wait");
			xfer(1'b0, 20'h00010, 16'h0000, rdData);
			chk(rdData, 16'hbeef, "array after abort");
		end
		$display("test abort done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{resetn, reqValid, reqWrite, resetReq, opBusy, opErase} = 6'h00;
		{reqAddr, reqData} = 36'h000000000;
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		t_basic();
		t_abort();
		wrap_up();
	end
endmodule // tb_top
